// ---- rtl/adcss_defs.vh ----
// Constants for the converter control/status sequencer.
// Assumes a 32-bit APB bus with word-aligned registers and a 25 MHz clock.
`ifndef ADCSS_DEFS_VH
`define ADCSS_DEFS_VH

// Register byte offsets
`define ADCSS_OFF_CSR 8'h00
`define ADCSS_OFF_CR 8'h04
`define ADCSS_OFF_RES_A 8'h08
`define ADCSS_OFF_RES_B 8'h0C
`define ADCSS_OFF_RES_C 8'h10
`define ADCSS_OFF_RES_D 8'h14
`define ADCSS_OFF_IST 8'h18
`define ADCSS_OFF_IMSK 8'h1C

// Control/status field positions
`define ADCSS_CSR_END 7
`define ADCSS_CSR_IE 6
`define ADCSS_CSR_START 5
`define ADCSS_CSR_SCAN 4
`define ADCSS_CSR_SPEED 3
`define ADCSS_CR_TRIGGER_INPUT_ENABLE 7

// Reset values
`define ADCSS_CSR_RST 8'h00
`define ADCSS_CR_RST 8'h7E
`define ADCSS_CR_FIXED 8'h7E
`define ADCSS_RES_RST 16'h0000

// Conversion times in states (one state is one clock)
`define ADCSS_T_SLOW_FIRST 8'h86
`define ADCSS_T_FAST_FIRST 8'h46
`define ADCSS_T_SLOW_NEXT 8'h80
`define ADCSS_T_FAST_NEXT 8'h42

`endif

// ---- rtl/adcss_top.v ----
// Control, status and sequencing for a 10-bit successive-approximation converter.
// Assumes an APB master on CLK_I and a converter core that holds its result on CONV_DATA_I
// by the end of the conversion time counted here.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "adcss_defs.vh"

// What this block does
// - Single mode sets end flag at finish
// - Scan sets end flag after whole set
// - End flag clears on zero after read
// - Enable plus end flag requests interrupt
// - Writing start bit begins conversion
// - Single mode clears start bit itself
// - Scan runs until start cleared, standby
// - Mode bit picks single or scan
// - Speed bit picks 134 or 70 states
// - Channel field decoded per mode
// - Reduced package lacks inputs four-seven
// - Result goes to register by position
// - Results left aligned, low bits zero
// - Scan restarts from group first channel
// - Trigger edge sets start when enabled
module adcss_top #(
   parameter REDUCED_PKG = 0 // Group 1 inputs absent when 1
) (
   input wire CLK_I, // System clock, 25 MHz
   input wire SYS_RST_I, // Synchronous reset, active high
   input wire STANDBY_I, // Standby entry, level, same clock
   input wire PSEL_I, // APB select
   input wire PENABLE_I, // APB enable
   input wire PWRITE_I, // APB direction, 1 = write
   input wire [7:0] PADDR_I, // APB byte address
   input wire [31:0] PWDATA_I, // APB write data
   output wire [31:0] PRDATA_O, // APB read data
   output wire PREADY_O, // APB ready
   output wire PSLVERR_O, // APB error on unmapped address
   input wire EXT_TRIG_I, // External trigger pin, asynchronous
   input wire [9:0] CONV_DATA_I, // Result from converter core
   output wire CONV_BUSY_O, // Core converting
   output wire [2:0] CONV_CHAN_O, // Analog input being converted
   output wire CONV_SPEED_O, // Speed select to core
   output wire IRQ_O // Interrupt, level, active high
);

   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_CONV = 2'b10;

   reg [1:0] state_q, state_d;
   reg [7:0] cnt_q, cnt_d;
   reg [1:0] idx_q, idx_d;
   reg end_q, end_d;
   reg ie_q, ie_d;
   reg start_q, start_d;
   reg scan_q, scan_d;
   reg speed_q, speed_d;
   reg [2:0] chan_q, chan_d;
   reg trigger_input_enable_q, trigger_input_enable_d;
   reg cr0_q, cr0_d;
   reg end_seen_q, end_seen_d;
   reg ist_q, ist_d;
   reg imsk_q, imsk_d;
   reg [9:0] res_q [0:3];
   reg [31:0] prdata_q;
   reg pready_q, pslverr_q;
   reg irq_q, busy_q, cspeed_q;
   reg [2:0] cchan_q;
   reg trig_s1_q, trig_s2_q, trig_s3_q;

   wire setup = PSEL_I & ~PENABLE_I;
   wire acc = PSEL_I & PENABLE_I & pready_q;
   wire wr = acc & PWRITE_I;
   wire rd = acc & ~PWRITE_I;
   wire wr_csr = wr & (PADDR_I == `ADCSS_OFF_CSR);
   wire [7:0] csr_val = {end_q, ie_q, start_q, scan_q, speed_q, chan_q};
   // result left aligned, low six bits zero
   wire [15:0] res_a = {res_q[0], 6'h00};
   wire [15:0] res_b = {res_q[1], 6'h00};
   wire [15:0] res_c = {res_q[2], 6'h00};
   wire [15:0] res_d = {res_q[3], 6'h00};
   wire trig_fall = trig_s3_q & ~trig_s2_q & trigger_input_enable_q;
   wire [1:0] pos = scan_q ? idx_q : chan_q[1:0];
   // group 1 reads zero on reduced package
   wire no_input = (REDUCED_PKG != 0) & chan_q[2];
   wire conv_done = (state_q == ST_CONV) & (cnt_q == 8'h01);

   reg done_set;
   reg [9:0] res_new;

   // Trigger pin synchroniser and edge stage
   always @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         trig_s1_q <= 1'b1;
         trig_s2_q <= 1'b1;
         trig_s3_q <= 1'b1;
      end else begin
         trig_s1_q <= EXT_TRIG_I;
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
      end
   end

   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      idx_d = idx_q;
      ie_d = ie_q;
      start_d = start_q;
      scan_d = scan_q;
      speed_d = speed_q;
      chan_d = chan_q;
      trigger_input_enable_d = trigger_input_enable_q;
      cr0_d = cr0_q;
      ist_d = ist_q;
      imsk_d = imsk_q;
      end_seen_d = end_seen_q;
      end_d = end_q;
      done_set = 1'b0;
      res_new = no_input ? 10'h000 : CONV_DATA_I;
      if (wr_csr) begin
         ie_d = PWDATA_I[`ADCSS_CSR_IE];
         start_d = PWDATA_I[`ADCSS_CSR_START];
         scan_d = PWDATA_I[`ADCSS_CSR_SCAN];
         speed_d = PWDATA_I[`ADCSS_CSR_SPEED];
         chan_d = PWDATA_I[2:0];
         // zero clears only after reading one
         if (!PWDATA_I[`ADCSS_CSR_END] && end_seen_q) begin
            end_d = 1'b0;
            end_seen_d = 1'b0;
         end
         // writing one leaves end flag alone
      end
      // arm clear only on a returned one
      if (rd && (PADDR_I == `ADCSS_OFF_CSR) && prdata_q[`ADCSS_CSR_END])
         end_seen_d = 1'b1;
      if (wr && (PADDR_I == `ADCSS_OFF_CR)) begin
         trigger_input_enable_d = PWDATA_I[`ADCSS_CR_TRIGGER_INPUT_ENABLE];
         cr0_d = PWDATA_I[0];
      end
      if (wr && (PADDR_I == `ADCSS_OFF_IST) && PWDATA_I[0])
         ist_d = 1'b0;
      if (wr && (PADDR_I == `ADCSS_OFF_IMSK))
         imsk_d = PWDATA_I[0];
      if (trig_fall)
         start_d = 1'b1;
      case (state_q)
         ST_IDLE: begin
            // First conversion of a run takes the longer time
            if (start_d) begin
               state_d = ST_CONV;
               idx_d = 2'b00;
               cnt_d = speed_d ? `ADCSS_T_FAST_FIRST : `ADCSS_T_SLOW_FIRST;
            end
         end
         ST_CONV: begin
            cnt_d = cnt_q - 8'h01;
            if (conv_done) begin
               if (!scan_q) begin
                  done_set = 1'b1;
                  start_d = 1'b0;
                  state_d = ST_IDLE;
               end else begin
                  // end flag after last of set
                  if (idx_q == chan_q[1:0]) begin
                     done_set = 1'b1;
                     idx_d = 2'b00;
                  end else begin
                     idx_d = idx_q + 2'b01;
                  end
                  cnt_d = speed_q ? `ADCSS_T_FAST_NEXT : `ADCSS_T_SLOW_NEXT;
               end
            end
            // scan stops only when start drops
            if (!start_d) begin
               state_d = ST_IDLE;
               idx_d = 2'b00;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (STANDBY_I) begin
         start_d = 1'b0;
         state_d = ST_IDLE;
         idx_d = 2'b00;
      end
      // Hardware set wins over software clear
      if (done_set) begin
         end_d = 1'b1;
         ist_d = 1'b1;
      end
   end

   always @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         state_q <= ST_IDLE;
         cnt_q <= 8'h00;
         idx_q <= 2'b00;
         end_q <= 1'b0;
         ie_q <= 1'b0;
         start_q <= 1'b0;
         scan_q <= 1'b0;
         speed_q <= 1'b0;
         chan_q <= 3'b000;
         trigger_input_enable_q <= 1'b0;
         cr0_q <= 1'b0;
         end_seen_q <= 1'b0;
         ist_q <= 1'b0;
         imsk_q <= 1'b0;
         irq_q <= 1'b0;
         busy_q <= 1'b0;
         cspeed_q <= 1'b0;
         cchan_q <= 3'b000;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         idx_q <= idx_d;
         end_q <= end_d;
         ie_q <= ie_d;
         start_q <= start_d;
         scan_q <= scan_d;
         speed_q <= speed_d;
         chan_q <= chan_d;
         trigger_input_enable_q <= trigger_input_enable_d;
         cr0_q <= cr0_d;
         end_seen_q <= end_seen_d;
         ist_q <= ist_d;
         imsk_q <= imsk_d;
         // end flag with enable requests interrupt
         irq_q <= (end_d & ie_d) | (ist_d & imsk_d);
         busy_q <= (state_d == ST_CONV);
         cspeed_q <= speed_d;
         cchan_q <= {chan_d[2], scan_d ? idx_d : chan_d[1:0]};
      end
   end

   // result stored by position in group
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_res
         always @(posedge CLK_I) begin
            if (SYS_RST_I)
               res_q[g] <= 10'h000;
            else if (conv_done && ({30'h0, pos} == g))
               res_q[g] <= res_new;
         end
      end
   endgenerate

   // Read data latched in setup, no wait states
   always @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         pready_q <= 1'b1;
         pslverr_q <= 1'b0;
         case (PADDR_I)
            `ADCSS_OFF_CSR: prdata_q <= {24'h000000, csr_val};
            `ADCSS_OFF_CR: prdata_q <= {24'h000000, trigger_input_enable_q, 6'h3F, cr0_q};
            `ADCSS_OFF_RES_A: prdata_q <= {16'h0000, res_a};
            `ADCSS_OFF_RES_B: prdata_q <= {16'h0000, res_b};
            `ADCSS_OFF_RES_C: prdata_q <= {16'h0000, res_c};
            `ADCSS_OFF_RES_D: prdata_q <= {16'h0000, res_d};
            `ADCSS_OFF_IST: prdata_q <= {31'h00000000, ist_q};
            `ADCSS_OFF_IMSK: prdata_q <= {31'h00000000, imsk_q};
            default: begin
               prdata_q <= 32'h00000000;
               pslverr_q <= 1'b1;
            end
         endcase
      end else begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   assign PRDATA_O = prdata_q;
   assign PREADY_O = pready_q;
   assign PSLVERR_O = pslverr_q;
   assign CONV_BUSY_O = busy_q;
   assign CONV_CHAN_O = cchan_q;
   assign CONV_SPEED_O = cspeed_q;
   assign IRQ_O = irq_q;

endmodule // adcss_top
`default_nettype wire

// ---- dv/adcss_chk.sv ----
// Port checker for the converter sequencer.
// Assumes binding onto adcss_top, one clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "adcss_defs.vh"
module adcss_chk (
   input wire CLK_I, // Clock
   input wire SYS_RST_I, // Reset
   input wire STANDBY_I, // Standby
   input wire PSEL_I, // Select
   input wire PENABLE_I, // Enable
   input wire PWRITE_I, // Direction
   input wire [7:0] PADDR_I, // Address
   input wire [31:0] PWDATA_I, // Write data
   input wire PREADY_O, // Ready
   input wire PSLVERR_O, // Error
   input wire CONV_BUSY_O, // Busy
   input wire IRQ_O // Interrupt
);
   wire setup = PSEL_I && !PENABLE_I;
   wire wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
   reg wr_q;
   always @(posedge CLK_I) wr_q <= wr;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   property p_rdy; setup |=> PREADY_O; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_pulse; PREADY_O |=> !PREADY_O; endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   property p_inacc; PREADY_O |-> PSEL_I && PENABLE_I; endproperty
   a_inacc: assert property (p_inacc) else $error("ready outside access");
   property p_errrdy; PSLVERR_O |-> PREADY_O; endproperty
   a_errrdy: assert property (p_errrdy) else $error("error without ready");
   property p_unmap; setup && PADDR_I > 8'h1C |=> PSLVERR_O; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped address accepted");
   property p_mapok; setup && PADDR_I <= 8'h1C && PADDR_I[1:0] == 2'b00 |=> !PSLVERR_O; endproperty
   a_mapok: assert property (p_mapok) else $error("mapped address refused");
   property p_start;
      wr && PADDR_I == `ADCSS_OFF_CSR && PWDATA_I[5] && !STANDBY_I |-> ##[1:3] CONV_BUSY_O;
   endproperty
   a_start: assert property (p_start) else $error("start did not begin conversion");
   property p_stby; STANDBY_I [*3] |-> !CONV_BUSY_O; endproperty
   a_stby: assert property (p_stby) else $error("busy during standby");
   property p_irq; IRQ_O && !wr && !wr_q |=> IRQ_O; endproperty
   a_irq: assert property (p_irq) else $error("interrupt dropped without write");
endmodule // adcss_chk
bind adcss_top adcss_chk adcss_chk_inst (.CLK_I, .SYS_RST_I, .STANDBY_I, .PSEL_I, .PENABLE_I,
   .PWRITE_I, .PADDR_I, .PWDATA_I, .PREADY_O, .PSLVERR_O, .CONV_BUSY_O, .IRQ_O);
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the converter sequencer.
// Drives APB, trigger, standby and core data directly.
`timescale 1ns/10ps
`default_nettype none
`include "adcss_defs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
   $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
   logic clk = 0, rst = 1, stby = 0, psel = 0, pen = 0, pwr = 0, trig = 1, er;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [9:0] cdata = 0;
   logic [2:0] c0;
   wire [31:0] prdata;
   wire pready, perr, busy, speed, irq;
   wire [2:0] chan;
   int err_count = 0, num_checks = 0, cyc = 0, n;
   adcss_top adcss_top_inst (.CLK_I(clk), .SYS_RST_I(rst), .STANDBY_I(stby), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(perr), .EXT_TRIG_I(trig), .CONV_DATA_I(cdata),
      .CONV_BUSY_O(busy), .CONV_CHAN_O(chan), .CONV_SPEED_O(speed), .IRQ_O(irq));
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cdata <= {7'h2A, chan};
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         results;
      end
   end
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      er = perr;
      rd = prdata;
      psel <= 0;
      pen <= 0;
   endtask
   task run(output int len);
      len = 0;
      @(negedge clk);
      while (busy !== 1'b1 && len < 20) begin len++; @(negedge clk); end
      c0 = chan;
      len = 0;
      while (busy === 1'b1 && len < 300) begin len++; @(negedge clk); end
      repeat (2) @(negedge clk);
   endtask
   task waitch(input logic [2:0] c);
      n = 0;
      while (chan !== c && n < 400) begin n++; @(negedge clk); end
      `CHK(chan, c)
   endtask
   task t_regs;
      xfer(0, `ADCSS_OFF_CSR, 0);
      `CHK(rd, 32'h0)
      xfer(0, `ADCSS_OFF_CR, 0);
      `CHK(rd, 32'h7E)
      xfer(1, `ADCSS_OFF_RES_D, 32'hFFFF);
      xfer(0, `ADCSS_OFF_RES_D, 0);
      `CHK(rd, 32'h0)
      xfer(0, 8'h20, 0);
      `CHK(er, 1'b1)
   endtask
   task t_single;
      xfer(1, `ADCSS_OFF_CSR, 32'h69);
      run(n);
      `CHK(n inside {[65:70]}, 1'b1)
      `CHK(c0, 3'd1)
      `CHK(speed, 1'b1)
      `CHK(irq, 1'b1)
      xfer(0, `ADCSS_OFF_RES_B, 0);
      `CHK(rd, {16'h0, 7'h2A, 3'd1, 6'h0})
   endtask
   task t_clear;
      xfer(1, `ADCSS_OFF_CSR, 32'h49);
      xfer(1, `ADCSS_OFF_CSR, 32'hC9);
      repeat (2) @(negedge clk);
      `CHK(irq, 1'b1)
      xfer(0, `ADCSS_OFF_CSR, 0);
      `CHK(rd, 32'hC9)
      xfer(1, `ADCSS_OFF_CSR, 32'h49);
      repeat (2) @(negedge clk);
      `CHK(irq, 1'b0)
      xfer(1, `ADCSS_OFF_IMSK, 1);
      repeat (2) @(negedge clk);
      `CHK(irq, 1'b1)
      xfer(1, `ADCSS_OFF_IST, 1);
      repeat (2) @(negedge clk);
      `CHK(irq, 1'b0)
   endtask
   task t_scan;
      xfer(1, `ADCSS_OFF_CSR, 32'h3A);
      waitch(3'd2);
      xfer(0, `ADCSS_OFF_CSR, 0);
      `CHK(rd[7], 1'b0)
      waitch(3'd0);
      xfer(0, `ADCSS_OFF_CSR, 0);
      `CHK(rd[7:0], 8'hBA)
      xfer(0, `ADCSS_OFF_RES_C, 0);
      `CHK(rd, {16'h0, 7'h2A, 3'd2, 6'h0})
      xfer(1, `ADCSS_OFF_CSR, 32'h1A);
      repeat (3) @(negedge clk);
      `CHK(busy, 1'b0)
      xfer(0, `ADCSS_OFF_CSR, 0);
      `CHK(rd[7:0], 8'h1A)
   endtask
   task t_trig;
      xfer(1, `ADCSS_OFF_CR, 32'h80);
      xfer(1, `ADCSS_OFF_CSR, 32'h06);
      @(posedge clk);
      trig <= 0;
      run(n);
      `CHK(n inside {[129:134]}, 1'b1)
      `CHK(c0, 3'd6)
      xfer(0, `ADCSS_OFF_RES_C, 0);
      `CHK(rd, {16'h0, 7'h2A, 3'd6, 6'h0})
      xfer(0, `ADCSS_OFF_CSR, 0);
      `CHK(rd[7:0], 8'h86)
      trig <= 1;
   endtask
   task t_stby;
      xfer(1, `ADCSS_OFF_CSR, 32'h38);
      repeat (10) @(posedge clk);
      stby <= 1;
      repeat (4) @(posedge clk);
      stby <= 0;
      @(negedge clk);
      `CHK(busy, 1'b0)
      xfer(0, `ADCSS_OFF_CSR, 0);
      `CHK(rd[5], 1'b0)
   endtask
   task results;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 0;
      t_regs;
      t_single;
      t_clear;
      t_scan;
      t_trig;
      t_stby;
      results;
   end
endmodule // tb_top
`default_nettype wire
